// file: logic/sps_pkg.sv
// Package for the power-up and supply-fault mode sequencer
package sps_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned WD_WINDOW_MS = 350;
	localparam int unsigned UV_HOLD_MS = 100;
	localparam int unsigned RST_PULSE_US = 15000;
	localparam int unsigned WD_WINDOW_CYC = WD_WINDOW_MS * (CLK_HZ / 1000);
	localparam int unsigned UV_HOLD_CYC = UV_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned RST_PULSE_CYC = RST_PULSE_US * (CLK_HZ / 1000000);
	localparam int CNT_W = 25;

	typedef enum logic [4:0] {
		ST_NREQ = 5'h01,
		ST_NORM = 5'h02,
		ST_WDRST = 5'h04,
		ST_UVRST = 5'h08,
		ST_SLEEP = 5'h10
	} sps_mode_t;

	typedef struct packed {
		logic rst_n;
		logic int_n;
		logic watchdog_fault_out_n;
		logic main_reg_on;
		logic tracking_supply_on;
		logic can_transmit_receive;
	} sps_pins_t;

	typedef struct packed {
		sps_mode_t mode;
		logic [CNT_W-1:0] cnt;
		logic uv_sleep;
		sps_pins_t pins;
	} sps_state_t;
endpackage : sps_pkg

// file: logic/sps_sequencer.sv
// Mode sequencer for power-up, watchdog and main-supply undervoltage
`timescale 1ns/100ps
// Function
// [RL1] After power-up enter Normal Request with CAN active, main on, tracking off.
// [RL2] No watchdog timing write within 350 ms of Normal Request gives a reset and re-entry.
// [RL3] Watchdog fault output is low while waiting for the first watchdog write.
// [RL4] First watchdog write moves to Normal: tracking on, fault released, reset high.
// [RL5] A missed refresh in Normal gives a reset and a return to Normal Request.
// [RL6] Undervoltage with Stop selected enters Reset: reset and interrupt low, fault high.
// [RL7] When the Stop-case overload goes away the device restarts in Normal Request.
// [RL8] Undervoltage with Sleep selected and battery fail clear holds Reset for 100 ms.
// [RL9] After that 100 ms the device enters Sleep with both supplies off.
// [RL10] Windows are counted in clock cycles and restart on each mode entry.
module sps_sequencer
	import sps_pkg::*;
#(
	parameter int unsigned WD_CYC = WD_WINDOW_CYC,
	parameter int unsigned UV_CYC = UV_HOLD_CYC,
	parameter int unsigned RP_CYC = RST_PULSE_CYC
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_WD_WRITE,
	input wire logic I_WD_REFRESH,
	input wire logic I_WD_MISSED,
	input wire logic I_MAIN_UV,
	input wire logic I_SLEEP_SELECTED,
	input wire logic I_BATTERY_FAIL_FLAG,
	output logic O_RST_N,
	output logic O_INT_N,
	output logic O_WATCHDOG_FAULT_OUT_N,
	output logic O_MAIN_REG_ON,
	output logic O_TRACKING_SUPPLY_ON,
	output logic O_CAN_TRANSMIT_RECEIVE,
	output logic [4:0] O_MODE
);
	sps_state_t s_q, s_d;

	function automatic sps_pins_t pins_for(input sps_mode_t m);
		sps_pins_t p;
		p = '{rst_n: 1'b1, int_n: 1'b1, watchdog_fault_out_n: 1'b1,
			main_reg_on: 1'b1, tracking_supply_on: 1'b0,
			can_transmit_receive: 1'b1};
		unique case (m)
			ST_NREQ: p.watchdog_fault_out_n = 1'b0; // RL1 RL3
			ST_NORM: p.tracking_supply_on = 1'b1; // RL4
			ST_WDRST: begin
				p.rst_n = 1'b0;
				p.watchdog_fault_out_n = 1'b0; // RL3
			end
			ST_UVRST: begin
				p.rst_n = 1'b0; // RL6 RL8
				p.int_n = 1'b0;
			end
			ST_SLEEP: begin
				p.main_reg_on = 1'b0; // RL9
				p.can_transmit_receive = 1'b0;
			end
			default: p.rst_n = 1'b0;
		endcase
		return p;
	endfunction : pins_for

	function automatic logic [CNT_W-1:0] lim(input int unsigned c);
		return CNT_W'(c - 1);
	endfunction : lim

	always_comb begin
		s_d = s_q;
		s_d.cnt = s_q.cnt + 1'b1; // RL10
		unique case (s_q.mode)
			ST_NREQ: begin
				if (I_MAIN_UV) begin
					s_d.mode = ST_UVRST;
					s_d.uv_sleep = I_SLEEP_SELECTED && !I_BATTERY_FAIL_FLAG;
				end else if (I_WD_WRITE) begin
					s_d.mode = ST_NORM; // RL4
				end else if (s_q.cnt == lim(WD_CYC)) begin
					s_d.mode = ST_WDRST; // RL2
				end
			end
			ST_NORM: begin
				if (I_MAIN_UV) begin
					s_d.mode = ST_UVRST; // RL6 RL8
					s_d.uv_sleep = I_SLEEP_SELECTED && !I_BATTERY_FAIL_FLAG;
				end else if (I_WD_MISSED) begin
					s_d.mode = ST_WDRST; // RL5
				end
			end
			ST_WDRST: begin
				if (s_q.cnt == lim(RP_CYC))
					s_d.mode = ST_NREQ; // RL2 RL5
			end
			ST_UVRST: begin
				if (s_q.uv_sleep) begin
					if (s_q.cnt == lim(UV_CYC))
						s_d.mode = ST_SLEEP; // RL9
				end else if (!I_MAIN_UV) begin
					s_d.mode = ST_NREQ; // RL7
				end
			end
			ST_SLEEP: s_d.mode = ST_SLEEP;
			default: s_d.mode = ST_NREQ;
		endcase
		if (s_d.mode != s_q.mode)
			s_d.cnt = '0; // RL10
		s_d.pins = pins_for(s_d.mode);
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			s_q.mode <= ST_NREQ; // RL1
			s_q.cnt <= '0;
			s_q.uv_sleep <= 1'b0;
			s_q.pins <= 6'b110101;
		end else begin
			s_q <= s_d;
		end
	end

	assign O_RST_N = s_q.pins.rst_n;
	assign O_INT_N = s_q.pins.int_n;
	assign O_WATCHDOG_FAULT_OUT_N = s_q.pins.watchdog_fault_out_n;
	assign O_MAIN_REG_ON = s_q.pins.main_reg_on;
	assign O_TRACKING_SUPPLY_ON = s_q.pins.tracking_supply_on;
	assign O_CAN_TRANSMIT_RECEIVE = s_q.pins.can_transmit_receive;
	assign O_MODE = s_q.mode;

	power_up_a: assert property (@(posedge I_CLK) $fell(I_RST) |-> // RL1
		s_q.mode == ST_NREQ && O_MAIN_REG_ON && !O_TRACKING_SUPPLY_ON)
		else $error("Not in Normal Request after reset");
	wd_timeout_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL2
		s_q.mode == ST_NREQ && s_q.cnt == lim(WD_CYC) && !I_WD_WRITE
		&& !I_MAIN_UV |=> !O_RST_N)
		else $error("No reset after watchdog window");
	wd_fault_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL3
		s_q.mode inside {ST_NREQ, ST_WDRST} |-> !O_WATCHDOG_FAULT_OUT_N)
		else $error("Fault output high while waiting");
	first_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_q.mode == ST_NREQ && I_WD_WRITE && !I_MAIN_UV |=> // RL4
		O_TRACKING_SUPPLY_ON && O_RST_N && O_WATCHDOG_FAULT_OUT_N)
		else $error("Normal entry outputs wrong");
	refresh_miss_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_q.mode == ST_NORM && I_WD_MISSED && !I_MAIN_UV |=> // RL5
		!O_RST_N ##[1:1000] 1'b1)
		else $error("No reset on missed refresh");
	uv_stop_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_q.mode == ST_UVRST && !s_q.uv_sleep |-> // RL6
		!O_RST_N && !O_INT_N && O_WATCHDOG_FAULT_OUT_N)
		else $error("Stop undervoltage outputs wrong");
	uv_recover_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_q.mode == ST_UVRST && !s_q.uv_sleep && !I_MAIN_UV |=> // RL7
		s_q.mode == ST_NREQ)
		else $error("No restart after overload");
	uv_sleep_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_q.mode == ST_UVRST && s_q.uv_sleep && s_q.cnt != lim(UV_CYC)
		|=> s_q.mode == ST_UVRST && !O_RST_N) // RL8
		else $error("Sleep reset period cut short");
	sleep_entry_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_q.mode == ST_UVRST && s_q.uv_sleep && s_q.cnt == lim(UV_CYC)
		|=> !O_MAIN_REG_ON && !O_TRACKING_SUPPLY_ON) // RL9
		else $error("Supplies not off in Sleep");
	cnt_restart_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_q.mode != $past(s_q.mode) |-> s_q.cnt == '0) // RL10
		else $error("Counter not restarted on entry");

	// Pin levels held for the whole of Normal Request and Normal, and CAN outside Sleep
	nreq_pins_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL1
		s_q.mode == ST_NREQ |-> O_MAIN_REG_ON && !O_TRACKING_SUPPLY_ON
		&& O_CAN_TRANSMIT_RECEIVE && O_RST_N)
		else $error("Normal Request pins wrong");
	can_active_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL1
		s_q.mode != ST_SLEEP |-> O_CAN_TRANSMIT_RECEIVE)
		else $error("CAN not active outside Sleep");
	norm_pins_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL4
		s_q.mode == ST_NORM |-> O_MAIN_REG_ON && O_TRACKING_SUPPLY_ON
		&& O_RST_N && O_WATCHDOG_FAULT_OUT_N)
		else $error("Normal pins wrong");
	norm_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL5
		s_q.mode == ST_NORM && I_WD_REFRESH && !I_WD_MISSED && !I_MAIN_UV
		|=> s_q.mode == ST_NORM && O_RST_N)
		else $error("Refreshed Normal left");

	// Watchdog reset pulse length and return
	wd_pulse_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL2
		s_q.mode == ST_WDRST && s_q.cnt != lim(RP_CYC)
		|=> s_q.mode == ST_WDRST && !O_RST_N)
		else $error("Watchdog reset pulse cut short");
	wd_return_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL2
		s_q.mode == ST_WDRST && s_q.cnt == lim(RP_CYC)
		|=> s_q.mode == ST_NREQ && s_q.cnt == '0)
		else $error("No return to Normal Request");
	nreq_wait_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL2
		s_q.mode == ST_NREQ && s_q.cnt != lim(WD_CYC) && !I_WD_WRITE
		&& !I_MAIN_UV |=> s_q.mode == ST_NREQ)
		else $error("Watchdog window left early");

	// Undervoltage entry and the low-power choice
	uv_entry_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL6
		s_q.mode inside {ST_NREQ, ST_NORM} && I_MAIN_UV
		|=> s_q.mode == ST_UVRST)
		else $error("Undervoltage not taken");
	uv_stop_sel_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL6
		s_q.mode inside {ST_NREQ, ST_NORM} && I_MAIN_UV
		&& (!I_SLEEP_SELECTED || I_BATTERY_FAIL_FLAG) |=> !s_q.uv_sleep)
		else $error("Stop case taken as Sleep");
	uv_sleep_sel_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_q.mode inside {ST_NREQ, ST_NORM} && I_MAIN_UV // RL8
		&& I_SLEEP_SELECTED && !I_BATTERY_FAIL_FLAG |=> s_q.uv_sleep)
		else $error("Sleep case not taken");
	stop_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL6
		s_q.mode == ST_UVRST && !s_q.uv_sleep && I_MAIN_UV
		|=> s_q.mode == ST_UVRST)
		else $error("Reset left while overloaded");
	sleep_stay_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RL9
		s_q.mode == ST_SLEEP |=> s_q.mode == ST_SLEEP && !O_MAIN_REG_ON
		&& !O_TRACKING_SUPPLY_ON)
		else $error("Sleep left or supplies on");
endmodule : sps_sequencer

// file: testbench/sps_host.sv
// Host model that writes and refreshes the watchdog
`timescale 1ns/100ps
module sps_host (
	input wire logic i_clk,
	input wire logic i_write_req,
	input wire logic i_miss_req,
	output logic o_wd_write = 1'b0,
	output logic o_wd_refresh = 1'b0,
	output logic o_wd_missed = 1'b0
);
	// One-cycle pulses, one edge after the request
	always @(posedge i_clk) begin
		o_wd_write <= i_write_req;
		o_wd_refresh <= i_write_req;
		o_wd_missed <= i_miss_req;
	end
endmodule : sps_host

// file: testbench/testbench.sv
// Bench for the power-up and supply-fault mode sequencer
`timescale 1ns/100ps
module testbench;
	import sps_pkg::*;
	localparam int WD_P = 20;
	localparam int UV_P = 10;
	logic I_CLK = 1'b0, I_RST = 1'b1, wr = 1'b0, ms = 1'b0;
	logic uv = 1'b0, slp = 1'b0, bf = 1'b0;
	logic wd_w, wd_r, wd_m, rst_n, int_n, flt_n, main_on, trk_on, can_on;
	logic [4:0] mode;
	int error_cnt = 0, comparisons = 0, cycles = 0, n;
	always #10 I_CLK = ~I_CLK;
	sps_host sps_host_inst (.i_clk(I_CLK), .i_write_req(wr), .i_miss_req(ms),
		.o_wd_write(wd_w), .o_wd_refresh(wd_r), .o_wd_missed(wd_m));
	sps_sequencer #(.WD_CYC(WD_P), .UV_CYC(UV_P), .RP_CYC(5))
		sps_sequencer_inst (.I_CLK, .I_RST, .I_WD_WRITE(wd_w),
		.I_WD_REFRESH(wd_r), .I_WD_MISSED(wd_m), .I_MAIN_UV(uv),
		.I_SLEEP_SELECTED(slp), .I_BATTERY_FAIL_FLAG(bf), .O_RST_N(rst_n),
		.O_INT_N(int_n), .O_WATCHDOG_FAULT_OUT_N(flt_n),
		.O_MAIN_REG_ON(main_on), .O_TRACKING_SUPPLY_ON(trk_on),
		.O_CAN_TRANSMIT_RECEIVE(can_on), .O_MODE(mode));
	task automatic chk(string nm, logic [10:0] s, logic [10:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic cyc(int k);
		repeat (k) @(posedge I_CLK);
		#1;
	endtask : cyc
	task automatic wait_mode(logic [4:0] m);
		n = 0;
		while (mode !== m && n < 200) begin
			cyc(1);
			n++;
		end
	endtask : wait_mode
	task automatic do_reset();
		I_RST = 1'b1;
		cyc(2);
		I_RST = 1'b0;
	endtask : do_reset
	task automatic to_normal();
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		wait_mode(5'h02);
	endtask : to_normal
	task automatic t_timeout();
		do_reset();
		chk("powerup", {mode, rst_n, int_n, flt_n, main_on, trk_on, can_on},
			{5'h01, 6'b110101});
		ms = 1'b1;
		cyc(1);
		ms = 1'b0;
		wait_mode(5'h04);
		chk("window", {10'h0, n >= WD_P - 2 && n <= WD_P + 1}, 11'h1);
		chk("wdrst", {4'h0, mode, rst_n, flt_n}, {4'h0, 5'h04, 2'b00});
		wait_mode(5'h01);
		chk("reentry", {5'h0, mode, flt_n}, {5'h0, 5'h01, 1'b0});
		wait_mode(5'h04);
		chk("window2", {10'h0, n >= WD_P - 2 && n <= WD_P + 1}, 11'h1);
		$display("test timeout done");
	endtask : t_timeout
	task automatic t_write();
		do_reset();
		to_normal();
		chk("normal", {mode, rst_n, int_n, flt_n, main_on, trk_on, can_on},
			{5'h02, 6'b111111});
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(2);
		chk("wrignored", {6'h0, mode}, {6'h0, 5'h02});
		ms = 1'b1;
		cyc(1);
		ms = 1'b0;
		wait_mode(5'h04);
		chk("missed", {10'h0, n <= 3}, 11'h1);
		wait_mode(5'h01);
		chk("back", {6'h0, mode}, {6'h0, 5'h01});
		$display("test write done");
	endtask : t_write
	task automatic t_stop_uv();
		do_reset();
		to_normal();
		uv = 1'b1;
		cyc(2);
		chk("stopuv", {3'h0, mode, rst_n, int_n, flt_n},
			{3'h0, 5'h08, 3'b001});
		uv = 1'b0;
		cyc(2);
		chk("restart", {6'h0, mode}, {6'h0, 5'h01});
		$display("test stop done");
	endtask : t_stop_uv
	task automatic t_bat_uv();
		do_reset();
		to_normal();
		slp = 1'b1;
		bf = 1'b1;
		uv = 1'b1;
		cyc(2);
		chk("batuv", {3'h0, mode, rst_n, int_n, flt_n},
			{3'h0, 5'h08, 3'b001});
		uv = 1'b0;
		cyc(2);
		chk("batback", {6'h0, mode}, {6'h0, 5'h01});
		slp = 1'b0;
		bf = 1'b0;
		$display("test battery fail done");
	endtask : t_bat_uv
	task automatic t_sleep_uv();
		do_reset();
		to_normal();
		slp = 1'b1;
		uv = 1'b1;
		wait_mode(5'h08);
		n = 0;
		while (mode === 5'h08 && n < 50) begin
			chk("hold", {8'h0, rst_n, int_n, flt_n}, 11'h1);
			cyc(1);
			n++;
		end
		chk("holdlen", {10'h0, n >= UV_P - 1 && n <= UV_P + 1}, 11'h1);
		chk("sleep", {4'h0, mode, main_on, trk_on}, {4'h0, 5'h10, 2'b00});
		uv = 1'b0;
		slp = 1'b0;
		$display("test sleep done");
	endtask : t_sleep_uv
	task automatic summarize();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	always @(posedge I_CLK) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			summarize();
		end
	end
	initial begin
		t_timeout();
		t_write();
		t_stop_uv();
		t_bat_uv();
		t_sleep_uv();
		summarize();
	end
endmodule : testbench
